// file: design/pse_regs_pkg.sv
// Constants shared by the quad policing/remap register ends.
// Assumes one 50 MHz core clock and a synchronous active-high reset.
// Contract
// - Bits 7:4 flag autoclass-capable PD per port
// - Bits 3:2/1:0 hold 2-bit signature codes
// - Signature valid at detect-check done event
// - Status clears on shutdown, power-off, resets, emergency
// - Pushbutton power-on loads both policing thresholds
// - Threshold is value*0.5 W, applied plus 5%
// - Four-pair checks each half, then the sum
// - Host may overwrite policing after power good
// - Two-pair limit returns to ff on clearing events
// - Map field per logical port selects physical set
// - Map resets to identity, codes 11 10 01 00
// - Map writes with duplicate codes are rejected
// - Host maps each physical port exactly once
// - Combined ports share one map nibble
// - Host writes map once; device idle until then
// - Map locked after first write until hardware reset
// - Host writes combine and map right after reset
// - Combine bit 1 selects four-pair fields
package pse_regs_pkg;
  localparam logic [7:0] status_addr = 8'h1c;
  localparam logic [7:0] limit2p_port1_addr = 8'h1e;
  localparam logic [7:0] limit2p_port2_addr = 8'h1f;
  localparam logic [7:0] limit2p_port3_addr = 8'h20;
  localparam logic [7:0] limit2p_port4_addr = 8'h21;
  localparam logic [7:0] port_map_addr = 8'h26;
  localparam logic [7:0] power_alloc_addr = 8'h29;
  localparam logic [7:0] limit4p_pair12_addr = 8'h2a;
  localparam logic [7:0] limit4p_pair34_addr = 8'h2b;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] limit_reset = 8'hff;
  localparam logic [7:0] port_map_reset = 8'he4;
  localparam logic [7:0] power_alloc_reset = 8'h00;
  localparam int autoclass_lsb = 4;
  localparam int sig12_lsb = 0;
  localparam int sig34_lsb = 2;
  localparam int combine12_bit = 3;
  localparam int combine34_bit = 7;
  localparam int alloc12_lsb = 0;
  localparam int alloc34_lsb = 4;
  // Limit LSB in milliwatts, margin in percent
  localparam int limit_lsb_mw = 500;
  localparam int limit_margin_pct = 5;
  localparam logic [7:0] read_idle = 8'h00;
endpackage : pse_regs_pkg

// file: design/pse_reg_link_if.sv
// Parallel register link joining the host end to the device end.
// Assumes both ends share i_core_clk; one access per cycle.
interface pse_reg_link_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport device_end (input wr_en, rd_en, addr, wdata, output rdata, rvalid);
  modport host_end (output wr_en, rd_en, addr, wdata, input rdata, rvalid);
endinterface : pse_reg_link_if

// file: design/pse_port_policing_remap_regs.sv
// Device end: autoclass/signature status, policing limits, port map.
// Assumes pin-side event inputs are already synchronous to i_core_clk.
module pse_port_policing_remap_regs #(
  parameter int n_ports = 4
) (
  input wire logic i_core_clk, // 50 MHz core clock
  input wire logic i_rst, // Synchronous reset, active high
  pse_reg_link_if.device_end link, // Register link
  input wire logic [n_ports-1:0] i_port_shutdown, // Port put in shutdown mode
  input wire logic [n_ports-1:0] i_pushbutton_power_off, // Pushbutton off pulse
  input wire logic [n_ports-1:0] i_pushbutton_power_on, // Pushbutton on pulse
  input wire logic [n_ports-1:0] i_per_port_soft_reset, // Per-port reset pulse
  input wire logic i_emergency_shutdown_event, // Emergency shutdown pulse
  input wire logic i_quad_reset, // Quad register reset pulse
  input wire logic [n_ports-1:0] i_power_good, // Port in power-good state
  input wire logic [n_ports-1:0] i_pd_auto_class_capable, // Autoclass seen
  input wire logic [n_ports-1:0] i_classification_done_event, // Class done pulse
  input wire logic [1:0] i_detect_check_done_event, // Pair 12, 34 detect done
  input wire logic [3:0] i_pair_signature_result, // 34 in 3:2, 12 in 1:0
  input wire logic [n_ports-1:0][7:0] i_negotiated_limit_2p, // Class-derived 2P
  input wire logic [1:0][7:0] i_negotiated_limit_4p, // Class-derived 4P
  input wire logic [n_ports-1:0][15:0] i_port_power_mw, // Measured power
  output logic o_device_enabled, // Map written, device may run
  output logic [n_ports-1:0][1:0] o_logical_to_physical_select, // Map
  output logic [1:0] o_pair_combine_select, // Pair 34, 12 combined
  output logic [n_ports-1:0] o_overpower_cut // Port over its limit
);
  typedef struct packed {
    logic [7:0] status;
    logic [n_ports-1:0][7:0] limit2p;
    logic [1:0][7:0] limit4p;
    logic [7:0] port_map;
    logic map_locked;
    logic [7:0] power_alloc;
    logic [7:0] rdata;
    logic rvalid;
    logic [n_ports-1:0] cut;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [n_ports-1:0] clear_port;
  logic [n_ports-1:0] over2p;
  logic [1:0] over4p;
  logic map_unique;
  logic [7:0] w;

  // Threshold in mW with 5% margin: limit*500*105/100
  function automatic logic [19:0] thresh_mw(input logic [7:0] lim);
    logic [31:0] t;
    t = 32'(lim) * 32'(pse_regs_pkg::limit_lsb_mw)
        * 32'(100 + pse_regs_pkg::limit_margin_pct) / 32'd100;
    return t[19:0];
  endfunction : thresh_mw

  always_comb
  begin
    w = link.wdata;
    map_unique = 1'b1;
    for (int a = 0; a < 4; a++)
    begin
      for (int b = a + 1; b < 4; b++)
      begin
        if (w[2*a +: 2] == w[2*b +: 2])
        begin
          map_unique = 1'b0;
        end
      end
    end
    for (int p = 0; p < n_ports; p++)
    begin
      clear_port[p] = i_port_shutdown[p] | i_pushbutton_power_off[p]
                      | i_per_port_soft_reset[p] | i_emergency_shutdown_event
                      | i_quad_reset;
      over2p[p] = {4'h0, i_port_power_mw[p]} > thresh_mw(cur.limit2p[p]);
    end
    for (int q = 0; q < 2; q++)
    begin
      over4p[q] = ({4'h0, i_port_power_mw[2*q]} + {4'h0, i_port_power_mw[2*q+1]})
                  > thresh_mw(cur.limit4p[q]);
    end
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.rvalid = 1'b0;
    // Host writes, then hardware sets, then clears win
    if (link.wr_en)
    begin
      case (link.addr)
        pse_regs_pkg::status_addr:
        begin
          next_cur.status = link.wdata;
        end
        pse_regs_pkg::limit2p_port1_addr:
        begin
          next_cur.limit2p[0] = link.wdata;
        end
        pse_regs_pkg::limit2p_port2_addr:
        begin
          next_cur.limit2p[1] = link.wdata;
        end
        pse_regs_pkg::limit2p_port3_addr:
        begin
          next_cur.limit2p[2] = link.wdata;
        end
        pse_regs_pkg::limit2p_port4_addr:
        begin
          next_cur.limit2p[3] = link.wdata;
        end
        pse_regs_pkg::limit4p_pair12_addr:
        begin
          next_cur.limit4p[0] = link.wdata;
        end
        pse_regs_pkg::limit4p_pair34_addr:
        begin
          next_cur.limit4p[1] = link.wdata;
        end
        pse_regs_pkg::power_alloc_addr:
        begin
          next_cur.power_alloc = link.wdata;
        end
        pse_regs_pkg::port_map_addr:
        begin
          if (!cur.map_locked)
          begin
            next_cur.map_locked = 1'b1;
            if (map_unique)
            begin
              next_cur.port_map = link.wdata;
            end
          end
        end
        default:
        begin
        end
      endcase
    end
    for (int p = 0; p < n_ports; p++)
    begin
      if (i_classification_done_event[p] && i_pd_auto_class_capable[p])
      begin
        next_cur.status[pse_regs_pkg::autoclass_lsb + p] = 1'b1;
      end
    end
    if (i_detect_check_done_event[0])
    begin
      next_cur.status[pse_regs_pkg::sig12_lsb +: 2] = i_pair_signature_result[1:0];
    end
    if (i_detect_check_done_event[1])
    begin
      next_cur.status[pse_regs_pkg::sig34_lsb +: 2] = i_pair_signature_result[3:2];
    end
    for (int p = 0; p < n_ports; p++)
    begin
      if (i_pushbutton_power_on[p])
      begin
        next_cur.limit2p[p] = i_negotiated_limit_2p[p];
        next_cur.limit4p[p/2] = i_negotiated_limit_4p[p/2];
      end
      if (clear_port[p])
      begin
        next_cur.limit2p[p] = pse_regs_pkg::limit_reset;
        next_cur.status = pse_regs_pkg::status_reset;
      end
    end
    if (i_quad_reset)
    begin
      next_cur.limit4p = {2{pse_regs_pkg::limit_reset}};
      next_cur.power_alloc = pse_regs_pkg::power_alloc_reset;
    end
    for (int p = 0; p < n_ports; p++)
    begin
      if (cur.power_alloc[p < 2 ? pse_regs_pkg::combine12_bit : pse_regs_pkg::combine34_bit])
      begin
        next_cur.cut[p] = cur.map_locked & i_power_good[p] & (over2p[p] | over4p[p/2]);
      end
      else
      begin
        next_cur.cut[p] = cur.map_locked & i_power_good[p] & over2p[p];
      end
    end
    next_cur.rdata = pse_regs_pkg::read_idle;
    if (link.rd_en)
    begin
      next_cur.rvalid = 1'b1;
      case (link.addr)
        pse_regs_pkg::status_addr: next_cur.rdata = cur.status;
        pse_regs_pkg::limit2p_port1_addr: next_cur.rdata = cur.limit2p[0];
        pse_regs_pkg::limit2p_port2_addr: next_cur.rdata = cur.limit2p[1];
        pse_regs_pkg::limit2p_port3_addr: next_cur.rdata = cur.limit2p[2];
        pse_regs_pkg::limit2p_port4_addr: next_cur.rdata = cur.limit2p[3];
        pse_regs_pkg::limit4p_pair12_addr: next_cur.rdata = cur.limit4p[0];
        pse_regs_pkg::limit4p_pair34_addr: next_cur.rdata = cur.limit4p[1];
        pse_regs_pkg::port_map_addr: next_cur.rdata = cur.port_map;
        pse_regs_pkg::power_alloc_addr: next_cur.rdata = cur.power_alloc;
        default: next_cur.rdata = pse_regs_pkg::read_idle;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cur <= '0;
      cur.status <= pse_regs_pkg::status_reset;
      cur.limit2p <= {n_ports{pse_regs_pkg::limit_reset}};
      cur.limit4p <= {2{pse_regs_pkg::limit_reset}};
      cur.port_map <= pse_regs_pkg::port_map_reset;
      cur.power_alloc <= pse_regs_pkg::power_alloc_reset;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign link.rdata = cur.rdata;
  assign link.rvalid = cur.rvalid;
  assign o_device_enabled = cur.map_locked;
  always_comb
  begin
    for (int p = 0; p < n_ports; p++)
    begin
      o_logical_to_physical_select[p] = cur.port_map[2*p +: 2];
    end
  end
  assign o_pair_combine_select = {cur.power_alloc[pse_regs_pkg::combine34_bit],
                                  cur.power_alloc[pse_regs_pkg::combine12_bit]};
  assign o_overpower_cut = cur.cut;
endmodule : pse_port_policing_remap_regs

// file: design/pse_reg_host.sv
// Host end: writes combine and map after reset, then serves user accesses.
// Assumes the device end on the same clock answers reads one cycle later.
module pse_reg_host (
  input wire logic i_core_clk, // 50 MHz core clock
  input wire logic i_rst, // Synchronous reset, active high
  pse_reg_link_if.host_end link, // Register link
  input wire logic [7:0] i_init_map, // Map to program, each code once
  input wire logic [7:0] i_init_alloc, // Combine/allocation to program
  input wire logic i_req, // User access request
  input wire logic i_we, // 1 write, 0 read
  input wire logic [7:0] i_addr, // User address
  input wire logic [7:0] i_wdata, // User write data
  output logic o_ready, // Init done, accepting requests
  output logic o_rvalid, // Read data valid pulse
  output logic [7:0] o_rdata // Read data
);
  typedef enum logic [2:0] {
    st_alloc = 3'b001,
    st_map = 3'b010,
    st_run = 3'b100
  } phase_t;
  typedef struct packed {
    phase_t phase;
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rvalid;
    logic [7:0] rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.wr_en = 1'b0;
    next_cur.rd_en = 1'b0;
    next_cur.rvalid = link.rvalid;
    if (link.rvalid)
    begin
      next_cur.rdata = link.rdata;
    end
    case (cur.phase)
      st_alloc:
      begin
        next_cur.wr_en = 1'b1;
        next_cur.addr = pse_regs_pkg::power_alloc_addr;
        next_cur.wdata = i_init_alloc;
        next_cur.phase = st_map;
      end
      st_map:
      begin
        next_cur.wr_en = 1'b1;
        next_cur.addr = pse_regs_pkg::port_map_addr;
        next_cur.wdata = i_init_map;
        next_cur.phase = st_run;
      end
      st_run:
      begin
        if (i_req)
        begin
          next_cur.wr_en = i_we & (i_addr != pse_regs_pkg::port_map_addr);
          next_cur.rd_en = ~i_we;
          next_cur.addr = i_addr;
          next_cur.wdata = i_wdata;
        end
      end
      default:
      begin
        next_cur.phase = st_alloc;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cur <= '0;
      cur.phase <= st_alloc;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign link.wr_en = cur.wr_en;
  assign link.rd_en = cur.rd_en;
  assign link.addr = cur.addr;
  assign link.wdata = cur.wdata;
  assign o_ready = (cur.phase == st_run);
  assign o_rvalid = cur.rvalid;
  assign o_rdata = cur.rdata;
endmodule : pse_reg_host

// file: testbench/pse_reg_link_checker.sv
// Link checker between the host end and the device end.
// Assumes one core clock and a synchronous active-high reset.
module pse_reg_link_checker (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Sync reset
  input wire logic i_wr_en, // Write strobe
  input wire logic i_rd_en, // Read strobe
  input wire logic [7:0] i_addr, // Address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic [7:0] i_rdata, // Read data
  input wire logic i_rvalid // Read valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic map_done;
  logic map_wr;
  logic [7:0] exp_map;
  logic [3:0] codes;
  assign map_wr = i_wr_en && i_addr == pse_regs_pkg::port_map_addr;
  assign codes = (4'h1 << i_wdata[1:0]) | (4'h1 << i_wdata[3:2]) | (4'h1 << i_wdata[5:4])
    | (4'h1 << i_wdata[7:6]);
  // First map write sticks only with four distinct codes
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      map_done <= 1'b0;
      exp_map <= pse_regs_pkg::port_map_reset;
    end
    else if (map_wr && !map_done)
    begin
      map_done <= 1'b1;
      exp_map <= (codes == 4'hf) ? i_wdata : exp_map;
    end
  end
  chk_read_answer: assert property (i_rd_en |=> i_rvalid)
    else $error("read not answered");
  chk_rvalid_cause: assert property (i_rvalid |-> $past(i_rd_en))
    else $error("valid without read");
  chk_idle_rdata: assert property (!i_rvalid |-> i_rdata == pse_regs_pkg::read_idle)
    else $error("read data not idle");
  chk_map_readback: assert property (i_rd_en && i_addr == pse_regs_pkg::port_map_addr
    |=> i_rdata == exp_map)
    else $error("map read back wrong");
  chk_map_once: assert property (map_wr |-> !map_done)
    else $error("map written twice");
  chk_one_access: assert property (!(i_wr_en && i_rd_en))
    else $error("read and write together");
  chk_init_alloc: assert property ($fell(i_rst) |=> i_wr_en
    && i_addr == pse_regs_pkg::power_alloc_addr)
    else $error("combine not written first");
  chk_init_map: assert property ($fell(i_rst) |=> ##1 map_wr)
    else $error("map not written second");
endmodule : pse_reg_link_checker

// file: testbench/pse_port_policing_remap_regs_test.sv
// Bench joining host and device ends over the register link.
// Assumes the host programs combine and map after each reset.
module pse_port_policing_remap_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic req, we, emerg, qrst, ready, rvalid_u, enabled;
  logic [7:0] addr, wdata, rd, rdata_u;
  logic [7:0] init_map = 8'he4;
  logic [3:0] shut, pb_off, pb_on, srst, cap, cdone, sig, cut;
  logic [1:0] ddone, comb;
  logic [3:0][1:0] map_sel;
  logic [3:0][7:0] lim2 = '1;
  logic [1:0][7:0] lim4 = '1;
  logic [3:0][15:0] pwr = '0;
  logic [3:0] pg = 4'hf;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  pse_reg_link_if pse_reg_link_if_i ();
  pse_reg_host pse_reg_host_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .link(pse_reg_link_if_i.host_end), .i_init_map(init_map), .i_init_alloc(8'h08),
    .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata), .o_ready(ready),
    .o_rvalid(rvalid_u), .o_rdata(rdata_u));
  pse_port_policing_remap_regs pse_port_policing_remap_regs_i (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .link(pse_reg_link_if_i.device_end), .i_port_shutdown(shut),
    .i_pushbutton_power_off(pb_off), .i_pushbutton_power_on(pb_on),
    .i_per_port_soft_reset(srst), .i_emergency_shutdown_event(emerg), .i_quad_reset(qrst),
    .i_power_good(pg), .i_pd_auto_class_capable(cap), .i_classification_done_event(cdone),
    .i_detect_check_done_event(ddone), .i_pair_signature_result(sig),
    .i_negotiated_limit_2p(lim2), .i_negotiated_limit_4p(lim4), .i_port_power_mw(pwr),
    .o_device_enabled(enabled), .o_logical_to_physical_select(map_sel),
    .o_pair_combine_select(comb), .o_overpower_cut(cut));
  pse_reg_link_checker pse_reg_link_checker_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_wr_en(pse_reg_link_if_i.wr_en), .i_rd_en(pse_reg_link_if_i.rd_en),
    .i_addr(pse_reg_link_if_i.addr), .i_wdata(pse_reg_link_if_i.wdata),
    .i_rdata(pse_reg_link_if_i.rdata), .i_rvalid(pse_reg_link_if_i.rvalid));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Driven one ns after an edge, so #20 keeps that phase
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    while (ready !== 1'b1) #20;
    {req, we, addr, wdata} = {1'b1, w, a, d};
    #20;
    req = 1'b0;
    #20;
    while (!w && rvalid_u !== 1'b1) #20;
    rd = rdata_u;
  endtask : access
  task automatic restart(input logic [7:0] m);
    i_rst = 1'b1;
    init_map = m;
    #60;
    i_rst = 1'b0;
    while (ready !== 1'b1) #20;
    // Map write lands one edge after ready rises
    #20;
  endtask : restart
  task automatic reset_values();
    logic [7:0] a [9] = '{8'h1c, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h26, 8'h2a, 8'h2b, 8'h1d};
    logic [7:0] e [9] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'he4, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 9; i++)
    begin
      access(1'b0, a[i], 8'h00);
      check("reset value", rd, e[i]);
    end
    check("combine", comb, 2'h1);
    check("enabled", enabled, 1'b1);
  endtask : reset_values
  task automatic status_codes();
    logic [3:0] acc;
    acc = 4'h0;
    for (int j = 0; j < 4; j++)
    begin
      acc = acc | (4'h1 << j);
      {cap, sig, cdone, ddone} = {4'h1 << j, j[1:0], ~j[1:0], 4'hf, 2'h3};
      #20;
      {cap, cdone, ddone} = '0;
      access(1'b0, 8'h1c, 8'h00);
      check("status", rd, {acc, j[1:0], ~j[1:0]});
    end
  endtask : status_codes
  task automatic policing();
    lim2[2] = 8'h14;
    lim4[0] = 8'h28;
    pb_on = 4'h5;
    #20;
    pb_on = 4'h0;
    access(1'b0, 8'h20, 8'h00);
    check("limit 2p", rd, 8'h14);
    access(1'b0, 8'h2a, 8'h00);
    check("limit 4p", rd, 8'h28);
    pwr[2] = 16'h2904;
    #60;
    check("cut at limit", cut[2], 1'b0);
    pwr[2] = 16'h2905;
    #60;
    check("cut above", cut[2], 1'b1);
    pg[2] = 1'b0;
    #40;
    check("cut not powered", cut[2], 1'b0);
    pg[2] = 1'b1;
    access(1'b1, 8'h20, 8'h28);
    #40;
    check("cut host limit", cut[2], 1'b0);
    pwr[1:0] = {16'h2af8, 16'h2af8};
    #60;
    check("cut pair sum", cut[1:0], 2'h3);
    pwr[1:0] = {16'h2710, 16'h2710};
    #60;
    check("pair under", cut[1:0], 2'h0);
  endtask : policing
  task automatic clear_sources();
    for (int k = 0; k < 5; k++)
    begin
      access(1'b1, 8'h1e, 8'h10);
      {cap, cdone, ddone, sig} = {4'hf, 4'hf, 2'h3, 4'hf};
      #20;
      {cap, cdone, ddone, shut[0], pb_off[0]} = {10'h000, k == 0, k == 1};
      {srst[0], emerg, qrst} = {k == 2, k == 3, k == 4};
      #20;
      {shut, pb_off, srst, emerg, qrst} = '0;
      access(1'b0, 8'h1c, 8'h00);
      check("status cleared", rd, 8'h00);
      access(1'b0, 8'h1e, 8'h00);
      check("limit restored", rd, 8'hff);
    end
  endtask : clear_sources
  task automatic remap();
    restart(8'h1b);
    check("select", map_sel, 8'h1b);
    access(1'b1, 8'h26, 8'he4);
    access(1'b0, 8'h26, 8'h00);
    check("map locked", rd, 8'h1b);
    restart(8'h50);
    access(1'b0, 8'h26, 8'h00);
    check("map duplicate", rd, 8'he4);
  endtask : remap
  task automatic summarize();
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial
  begin
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    {shut, pb_off, pb_on, srst, cap, cdone, sig, ddone, emerg, qrst, req, we} = '0;
    {addr, wdata} = '0;
    #11;
    restart(8'he4);
    reset_values();
    status_codes();
    policing();
    clear_sources();
    remap();
    summarize();
  end
endmodule : pse_port_policing_remap_regs_test
